// >>> logic/tfs_defs.vh
// Purpose: Constants for the tachometer function settings block.
// Assumes: 100 MHz clock, all values plain Verilog defines.
// Notes: Included by both design files.
`ifndef TFS_DEFS_VH
`define TFS_DEFS_VH
// Clock rate in kHz and derived timing counts.
`define TFS_CLK_KHZ 100000
`define TFS_CYC_PER_MS (`TFS_CLK_KHZ / 1000)
`define TFS_CYCLE_WINDOW_MS 1000
`define TFS_FAST_WINDOW_MS 200
`define TFS_CONT_WINDOW_MS 10
`define TFS_CYCLE_WINDOW_CYC (`TFS_CYCLE_WINDOW_MS * `TFS_CYC_PER_MS)
`define TFS_FAST_WINDOW_CYC (`TFS_FAST_WINDOW_MS * `TFS_CYC_PER_MS)
`define TFS_CONT_WINDOW_CYC (`TFS_CONT_WINDOW_MS * `TFS_CYC_PER_MS)
// Minimum input off time the source must keep for width mode.
`define TFS_WIDTH_GAP_MS 20
// Value limits.
`define TFS_CEIL_MIN 24'h00_0001
`define TFS_CEIL_MAX 24'h0F_423F
`define TFS_ALARM_MAX 14'h270F
`define TFS_ONCOUNT_UNIT 10'h3E8
// Display colour encodings.
`define TFS_COL_RED 2'h1
`define TFS_COL_GREEN 2'h2
`define TFS_COL_ORANGE 2'h3
// Colour select settings.
`define TFS_CSEL_RED 4'h0
`define TFS_CSEL_GREEN 4'h1
`define TFS_CSEL_ORANGE 4'h2
`define TFS_CSEL_R_G 4'h3
`define TFS_CSEL_G_R 4'h4
`define TFS_CSEL_R_O 4'h5
`define TFS_CSEL_O_R 4'h6
`define TFS_CSEL_G_O 4'h7
`define TFS_CSEL_O_G 4'h8
// Reset values.
`define TFS_MEAS_RESET 24'h00_0000
`define TFS_PEAK_RESET 24'h00_0000
`define TFS_BOTTOM_RESET 24'hFF_FFFF
`endif

// >>> logic/tfs_oncount.v
// Purpose: ON-transition counter with alarm for one control output.
// Assumes: Output level comes from logic on the same clock.
// Notes: Accumulator saturates; monitor shows count divided by 1000.
`timescale 1ns/1ns
`default_nettype none
`include "tfs_defs.vh"
module tfs_oncount (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Output level and alarm threshold in thousands
    input wire out_level,
    input wire [13:0] alarm_thousands,
    // Monitor and alarm
    output reg [13:0] monitor_thousands_reg,
    output reg alarm_reg
);
    reg prev_reg;
    reg [9:0] unit_reg;
    wire rising;
    wire at_max;
    assign rising = out_level & ~prev_reg;
    assign at_max = (monitor_thousands_reg == 14'h3FFF) &&
        (unit_reg == `TFS_ONCOUNT_UNIT - 10'h001);

    // Counts ON edges in a thousands-and-units pair.
    always @(posedge clock)
    begin
        if (rst)
        begin
            prev_reg <= 1'b0;
            unit_reg <= 10'h000;
            monitor_thousands_reg <= 14'h0000;
            alarm_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= out_level;
            if (rising && !at_max)
            begin
                if (unit_reg == `TFS_ONCOUNT_UNIT - 10'h001)
                begin
                    unit_reg <= 10'h000;
                    monitor_thousands_reg <= monitor_thousands_reg + 14'h0001;
                end
                else
                begin
                    unit_reg <= unit_reg + 10'h001;
                end
            end
            alarm_reg <= (alarm_thousands != 14'h0000) &&
                ((monitor_thousands_reg > alarm_thousands) ||
                 ((monitor_thousands_reg == alarm_thousands) && (unit_reg != 10'h000)));
        end
    end
endmodule // tfs_oncount
`default_nettype wire

// >>> logic/tfs_main.v
// Purpose: Tachometer function settings: measurement, compare, display colour.
// Assumes: One 100 MHz clock, synchronous reset at power-up.
// Notes: Settings are plain ports; non-volatile peak storage is external.
`timescale 1ns/1ns
`default_nettype none
`include "tfs_defs.vh"
module tfs_main (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Pulse input pin and polarity (1 = sourcing)
    input wire pulse_pin,
    input wire input_sourcing,
    // Measurement settings
    input wire width_mode,
    input wire unit_seconds,
    input wire fast_rate,
    input wire interval_continuous,
    input wire [31:0] startup_inhibit_time,
    // Compare settings
    input wire area_mode,
    input wire [23:0] stage_one_setpoint,
    input wire [23:0] stage_two_setpoint,
    input wire setpoint_write,
    input wire [23:0] hysteresis,
    input wire [31:0] output_release_delay,
    input wire [23:0] set_value_ceiling,
    input wire stage_swap,
    // Display and capture settings
    input wire [3:0] display_colour_select,
    input wire peak_bottom_capture_enable,
    input wire tracking_restart,
    input wire [23:0] stored_peak,
    input wire [13:0] output_one_oncount_alarm,
    input wire [13:0] output_two_oncount_alarm,
    // Results
    output reg [23:0] measured_reg,
    output reg control_output_one,
    output reg control_output_two,
    output reg [1:0] display_colour_reg,
    output reg [23:0] peak_reg,
    output reg [23:0] bottom_reg,
    output reg peak_store_reg,
    output reg setpoint_rejected_reg,
    output wire [13:0] output_one_oncount_monitor,
    output wire [13:0] output_two_oncount_monitor,
    output reg diag_error_reg
);
    // ********************************
    // Input conditioning
    // ********************************
    reg [2:0] sync_reg;
    reg level_reg;
    wire active_raw;
    assign active_raw = input_sourcing ? pulse_pin : ~pulse_pin;

    // Three-stage synchroniser; change taken when stages two and three agree.
    always @(posedge clock)
    begin
        if (rst)
        begin
            sync_reg <= 3'h0;
            level_reg <= 1'b0;
        end
        else
        begin
            sync_reg <= {sync_reg[1:0], active_raw};
            if (sync_reg[1] == sync_reg[2])
                level_reg <= sync_reg[2];
        end
    end

    // ********************************
    // Startup inhibit
    // ********************************
    reg [31:0] start_cnt_reg;
    reg running_reg;

    // Counts up to the startup interval after reset.
    always @(posedge clock)
    begin
        if (rst)
        begin
            start_cnt_reg <= 32'h0000_0000;
            running_reg <= 1'b0;
        end
        else if (!running_reg)
        begin
            if (start_cnt_reg >= startup_inhibit_time)
                running_reg <= 1'b1;
            else
                start_cnt_reg <= start_cnt_reg + 32'h0000_0001;
        end
    end

    // ********************************
    // Measurement
    // ********************************
    reg prev_level_reg;
    reg [31:0] gate_cnt_reg;
    reg [23:0] pulse_cnt_reg;
    reg [31:0] width_cnt_reg;
    reg [31:0] period_cnt_reg;
    reg [31:0] last_period_reg;
    reg meas_strobe_reg;
    wire rise;
    wire fall;
    wire [31:0] gate_len;
    assign rise = level_reg & ~prev_level_reg;
    assign fall = ~level_reg & prev_level_reg;
    assign gate_len = !fast_rate ? `TFS_CYCLE_WINDOW_CYC :
        (interval_continuous ? `TFS_CONT_WINDOW_CYC : `TFS_FAST_WINDOW_CYC);

    // Gates pulse counts, times periods and widths.
    always @(posedge clock)
    begin
        if (rst)
        begin
            prev_level_reg <= 1'b0;
            gate_cnt_reg <= 32'h0000_0000;
            pulse_cnt_reg <= 24'h00_0000;
            width_cnt_reg <= 32'h0000_0000;
            period_cnt_reg <= 32'h0000_0000;
            last_period_reg <= 32'h0000_0000;
            measured_reg <= `TFS_MEAS_RESET;
            meas_strobe_reg <= 1'b0;
        end
        else
        begin
            prev_level_reg <= level_reg;
            meas_strobe_reg <= 1'b0;
            if (running_reg)
            begin
                if (rise)
                begin
                    period_cnt_reg <= 32'h0000_0001;
                    last_period_reg <= period_cnt_reg;
                end
                else if (period_cnt_reg != 32'hFFFF_FFFF)
                    period_cnt_reg <= period_cnt_reg + 32'h0000_0001;
                if (width_mode)
                begin
                    if (rise)
                        width_cnt_reg <= 32'h0000_0000;
                    else if (level_reg)
                        width_cnt_reg <= width_cnt_reg + 32'h0000_0001;
                    if (fall)
                    begin
                        measured_reg <= width_cnt_reg[23:0];
                        meas_strobe_reg <= 1'b1;
                    end
                end
                else
                begin
                    if (gate_cnt_reg + 32'h0000_0001 >= gate_len)
                    begin
                        gate_cnt_reg <= 32'h0000_0000;
                        pulse_cnt_reg <= 24'h00_0000;
                        meas_strobe_reg <= 1'b1;
                        if (unit_seconds)
                            measured_reg <= last_period_reg[23:0];
                        else
                            measured_reg <= pulse_cnt_reg + {23'h00_0000, rise};
                    end
                    else
                    begin
                        gate_cnt_reg <= gate_cnt_reg + 32'h0000_0001;
                        if (rise)
                            pulse_cnt_reg <= pulse_cnt_reg + 24'h00_0001;
                    end
                end
            end
        end
    end

    // ********************************
    // Set values and comparison
    // ********************************
    reg [23:0] sv1_reg;
    reg [23:0] sv2_reg;
    reg cmp1_reg;
    reg cmp2_reg;
    reg [31:0] hold1_reg;
    reg [31:0] hold2_reg;
    reg stage1_reg;
    reg stage2_reg;
    wire ceil_ok;
    wire [23:0] ceil;
    assign ceil = (set_value_ceiling < `TFS_CEIL_MIN) ? `TFS_CEIL_MIN :
        ((set_value_ceiling > `TFS_CEIL_MAX) ? `TFS_CEIL_MAX : set_value_ceiling);
    assign ceil_ok = (stage_one_setpoint <= ceil) && (stage_two_setpoint <= ceil);

    // Latches set values and applies hysteresis and off delay.
    always @(posedge clock)
    begin
        if (rst)
        begin
            sv1_reg <= 24'h00_0000;
            sv2_reg <= 24'h00_0000;
            setpoint_rejected_reg <= 1'b0;
            cmp1_reg <= 1'b0;
            cmp2_reg <= 1'b0;
            hold1_reg <= 32'h0000_0000;
            hold2_reg <= 32'h0000_0000;
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end
        else
        begin
            if (setpoint_write)
            begin
                setpoint_rejected_reg <= !ceil_ok;
                if (ceil_ok)
                begin
                    sv1_reg <= stage_one_setpoint;
                    sv2_reg <= stage_two_setpoint;
                end
            end
            if (measured_reg >= sv1_reg)
                cmp1_reg <= 1'b1;
            else if ({1'b0, measured_reg} + {1'b0, hysteresis} < {1'b0, sv1_reg})
                cmp1_reg <= 1'b0;
            if (measured_reg >= sv2_reg)
                cmp2_reg <= 1'b1;
            else if ({1'b0, measured_reg} + {1'b0, hysteresis} < {1'b0, sv2_reg})
                cmp2_reg <= 1'b0;
            if (cmp1_reg)
            begin
                stage1_reg <= 1'b1;
                hold1_reg <= 32'h0000_0000;
            end
            else if (stage1_reg)
            begin
                if (hold1_reg >= output_release_delay)
                    stage1_reg <= 1'b0;
                else
                    hold1_reg <= hold1_reg + 32'h0000_0001;
            end
            if (cmp2_reg)
            begin
                stage2_reg <= 1'b1;
                hold2_reg <= 32'h0000_0000;
            end
            else if (stage2_reg)
            begin
                if (hold2_reg >= output_release_delay)
                    stage2_reg <= 1'b0;
                else
                    hold2_reg <= hold2_reg + 32'h0000_0001;
            end
        end
    end

    // ********************************
    // Outputs, colour and capture
    // ********************************
    reg [1:0] off_col;
    reg [1:0] on_col;
    reg any_on;

    // Picks the off and on colours of the selected setting.
    always @*
    begin
        off_col = `TFS_COL_RED;
        on_col = `TFS_COL_RED;
        any_on = area_mode ? control_output_one : (control_output_one | control_output_two);
        case (display_colour_select)
            `TFS_CSEL_RED: begin off_col = `TFS_COL_RED; on_col = `TFS_COL_RED; end
            `TFS_CSEL_GREEN: begin off_col = `TFS_COL_GREEN; on_col = `TFS_COL_GREEN; end
            `TFS_CSEL_ORANGE: begin off_col = `TFS_COL_ORANGE; on_col = `TFS_COL_ORANGE; end
            `TFS_CSEL_R_G: begin off_col = `TFS_COL_RED; on_col = `TFS_COL_GREEN; end
            `TFS_CSEL_G_R: begin off_col = `TFS_COL_GREEN; on_col = `TFS_COL_RED; end
            `TFS_CSEL_R_O: begin off_col = `TFS_COL_RED; on_col = `TFS_COL_ORANGE; end
            `TFS_CSEL_O_R: begin off_col = `TFS_COL_ORANGE; on_col = `TFS_COL_RED; end
            `TFS_CSEL_G_O: begin off_col = `TFS_COL_GREEN; on_col = `TFS_COL_ORANGE; end
            `TFS_CSEL_O_G: begin off_col = `TFS_COL_ORANGE; on_col = `TFS_COL_GREEN; end
            default: begin off_col = `TFS_COL_RED; on_col = `TFS_COL_RED; end
        endcase
    end

    // Drives outputs, colour and peak/bottom capture.
    always @(posedge clock)
    begin
        if (rst)
        begin
            control_output_one <= 1'b0;
            control_output_two <= 1'b0;
            display_colour_reg <= `TFS_COL_RED;
            peak_reg <= `TFS_PEAK_RESET;
            bottom_reg <= `TFS_BOTTOM_RESET;
            peak_store_reg <= 1'b0;
        end
        else
        begin
            control_output_one <= running_reg & (stage_swap ? stage2_reg : stage1_reg);
            control_output_two <= running_reg & (stage_swap ? stage1_reg : stage2_reg);
            display_colour_reg <= any_on ? on_col : off_col;
            peak_store_reg <= 1'b0;
            if (!running_reg || tracking_restart)
            begin
                peak_reg <= stored_peak;
                bottom_reg <= `TFS_BOTTOM_RESET;
            end
            else if (peak_bottom_capture_enable && meas_strobe_reg)
            begin
                if (measured_reg > peak_reg)
                begin
                    peak_reg <= measured_reg;
                    peak_store_reg <= 1'b1;
                end
                if (measured_reg < bottom_reg)
                    bottom_reg <= measured_reg;
            end
        end
    end

    // ********************************
    // ON counters
    // ********************************
    wire alarm1;
    wire alarm2;

    tfs_oncount u_cnt1 (
        .clock(clock),
        .rst(rst),
        .out_level(control_output_one),
        .alarm_thousands(output_one_oncount_alarm),
        .monitor_thousands_reg(output_one_oncount_monitor),
        .alarm_reg(alarm1)
    );
    tfs_oncount u_cnt2 (
        .clock(clock),
        .rst(rst),
        .out_level(control_output_two),
        .alarm_thousands(output_two_oncount_alarm),
        .monitor_thousands_reg(output_two_oncount_monitor),
        .alarm_reg(alarm2)
    );

    // Combines both alarms into the diagnostic flag.
    always @(posedge clock)
    begin
        if (rst)
            diag_error_reg <= 1'b0;
        else
            diag_error_reg <= alarm1 | alarm2;
    end
endmodule // tfs_main
`default_nettype wire

// >>> testbench/tfs_colour.svh
// Purpose: Expected display colour for a colour setting and output state.
// Assumes: Colour codes 1 red, 2 green, 3 orange; on means output one is lit, or either output when area mode is off.
// Notes: Included inside each module that needs it.
// fixed and paired colours
function automatic logic [1:0] colour_of(input logic [3:0] sel, input logic on);
    case (sel)
        4'h1: colour_of = 2'h2;
        4'h2: colour_of = 2'h3;
        4'h3: colour_of = on ? 2'h2 : 2'h1;
        4'h4: colour_of = on ? 2'h1 : 2'h2;
        4'h5: colour_of = on ? 2'h3 : 2'h1;
        4'h6: colour_of = on ? 2'h1 : 2'h3;
        4'h7: colour_of = on ? 2'h3 : 2'h2;
        4'h8: colour_of = on ? 2'h2 : 2'h3;
        default: colour_of = 2'h1;
    endcase
endfunction

// >>> testbench/tfs_main_asserts.sv
// Purpose: Port-level assertions for the tachometer settings block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to tfs_main below.
`timescale 1ns/1ns
`default_nettype none
module tfs_main_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Settings
    input wire logic pulse_pin,
    input wire logic input_sourcing,
    input wire logic width_mode,
    input wire logic [31:0] startup_inhibit_time,
    input wire logic area_mode,
    input wire logic [23:0] stage_one_setpoint,
    input wire logic [23:0] stage_two_setpoint,
    input wire logic setpoint_write,
    input wire logic [23:0] set_value_ceiling,
    input wire logic [3:0] display_colour_select,
    input wire logic peak_bottom_capture_enable,
    input wire logic tracking_restart,
    input wire logic [13:0] output_one_oncount_alarm,
    input wire logic [13:0] output_two_oncount_alarm,
    // Results
    input wire logic [23:0] measured_reg,
    input wire logic control_output_one,
    input wire logic control_output_two,
    input wire logic [1:0] display_colour_reg,
    input wire logic [23:0] peak_reg,
    input wire logic [23:0] bottom_reg,
    input wire logic peak_store_reg,
    input wire logic setpoint_rejected_reg,
    input wire logic [13:0] output_one_oncount_monitor,
    input wire logic [13:0] output_two_oncount_monitor,
    input wire logic diag_error_reg
);
    `include "tfs_colour.svh"
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic [31:0] up_cnt_reg;
    // Counts cycles since reset release, saturating at the top.
    always_ff @(posedge clock)
    begin
        if (rst)
            up_cnt_reg <= 32'h0000_0000;
        else if (up_cnt_reg != 32'hFFFF_FFFF)
            up_cnt_reg <= up_cnt_reg + 32'h0000_0001;
    end
    // Effective ceiling is clamped into its legal range.
    wire [23:0] ceil = (set_value_ceiling == 24'h00_0000) ? 24'h00_0001 :
        (set_value_ceiling > 24'h0F_423F) ? 24'h0F_423F : set_value_ceiling;
    wire too_high = (stage_one_setpoint > ceil) || (stage_two_setpoint > ceil);
    wire lit = area_mode ? control_output_one : (control_output_one | control_output_two);
    wire track_on = peak_bottom_capture_enable && !tracking_restart &&
        (up_cnt_reg > startup_inhibit_time + 32'h0000_0002);
    sequence key_steady;
        $stable({display_colour_select, area_mode, control_output_one, control_output_two})[*3];
    endsequence
    sequence input_idle;
        (width_mode && pulse_pin != input_sourcing)[*8];
    endsequence
    chk_inhibit_outputs: assert property (
        up_cnt_reg < startup_inhibit_time |->
        !control_output_one && !control_output_two && measured_reg == 24'h00_0000)
        else $error("outputs or measurement active during startup inhibit");
    chk_colour_map: assert property (
        key_steady |-> display_colour_reg == colour_of(display_colour_select, lit))
        else $error("display colour does not match setting and outputs");
    chk_reject_flag: assert property (
        setpoint_write |=> setpoint_rejected_reg == $past(too_high))
        else $error("set value rejection flag wrong");
    chk_reject_hold: assert property (
        !setpoint_write |=> $stable(setpoint_rejected_reg))
        else $error("rejection flag changed without a write");
    chk_peak_rise: assert property (
        track_on && !$past(tracking_restart) && $past(peak_bottom_capture_enable)
        |=> peak_reg >= $past(peak_reg))
        else $error("peak value fell while tracking");
    chk_bottom_fall: assert property (
        track_on && !$past(tracking_restart) && $past(peak_bottom_capture_enable)
        |=> bottom_reg <= $past(bottom_reg))
        else $error("bottom value rose while tracking");
    chk_monitor_mono: assert property (
        1'b1 |=> output_one_oncount_monitor >= $past(output_one_oncount_monitor) &&
        output_two_oncount_monitor >= $past(output_two_oncount_monitor))
        else $error("ON count monitor decreased");
    chk_alarm_off: assert property (
        (output_one_oncount_alarm == 14'h0000 && output_two_oncount_alarm == 14'h0000)[*3]
        |-> !diag_error_reg)
        else $error("diagnostic error with both alarms disabled");
    chk_store_pulse: assert property (
        peak_store_reg |=> !peak_store_reg)
        else $error("peak store strobe longer than one cycle");
    chk_store_on_rise: assert property (
        peak_store_reg |-> peak_reg > $past(peak_reg))
        else $error("peak store without a new peak");
    chk_width_hold: assert property (
        input_idle |=> $stable(measured_reg))
        else $error("width value changed with no input pulse");
endmodule // tfs_main_asserts
bind tfs_main tfs_main_asserts tfs_main_asserts_inst (.*);
`default_nettype wire

// >>> testbench/tfs_pulse_src.sv
// Purpose: Pulse sensor model on the tachometer input pin.
// Assumes: Changes the line just after the falling clock edge.
// Notes: Between pulses the line rests at the inactive level of the polarity.
`timescale 1ns/1ns
`default_nettype none
module tfs_pulse_src #(
    parameter int GAP_CYC = 2000000
) (
    // Clock and polarity
    input wire logic clock,
    input wire logic sourcing,
    // Sensor line
    output var logic pulse_pin
);
    always
    begin
        pulse_pin = !sourcing;
        @(sourcing);
    end
    // one pulse then the off gap
    task automatic send(input int width);
        @(negedge clock);
        pulse_pin = sourcing;
        repeat (width) @(negedge clock);
        pulse_pin = !sourcing;
        repeat (GAP_CYC) @(negedge clock);
    endtask
endmodule // tfs_pulse_src
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the tachometer settings block.
// Assumes: 100 MHz clock, inputs driven on the falling edge.
// Notes: Width mode mostly; cycle-mode gates are too long to simulate.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    `include "tfs_colour.svh"
    typedef struct {int id; logic [23:0] val; int tol;} tfs_note_t;
    tfs_note_t notes[$];
    string names[10] = '{"measured", "out_one", "out_two", "colour", "peak", "bottom",
        "rejected", "mon_one", "mon_two", "diag"};
    int checks = 0, mismatches = 0, cycles = 0, i, w;
    integer seed = 32'h0000_438F;
    logic clock = 1'b0, rst = 1'b1, sourcing = 1'b1, area = 1'b0, wr = 1'b0, swap = 1'b0;
    logic en = 1'b0, restart = 1'b0, pin, wmode = 1'b1, unit = 1'b0;
    logic [23:0] sv1 = 24'h00_0000, sv2 = 24'h00_0000, hyst = 24'h00_0000;
    logic [23:0] ceil = 24'h00_0000, stored = 24'h00_0000;
    logic [31:0] delay = 32'h0000_0000, inh = 32'h0000_012C;
    logic [3:0] sel = 4'h3;
    logic [13:0] al1 = 14'h0000, al2 = 14'h0000, mon1, mon2;
    logic [23:0] meas_v, peak_v, bot_v;
    logic o1, o2, store, rej, diag;
    logic [1:0] colour;
    // The off gap is cut short: the width logic does not time it.
    tfs_pulse_src #(.GAP_CYC(2000)) tfs_pulse_src_inst (.clock(clock), .sourcing(sourcing),
        .pulse_pin(pin));
    tfs_main tfs_main_inst (.clock(clock), .rst(rst), .pulse_pin(pin),
        .input_sourcing(sourcing), .width_mode(wmode), .unit_seconds(unit),
        .fast_rate(1'b0), .interval_continuous(1'b0), .startup_inhibit_time(inh),
        .area_mode(area), .stage_one_setpoint(sv1), .stage_two_setpoint(sv2),
        .setpoint_write(wr), .hysteresis(hyst), .output_release_delay(delay),
        .set_value_ceiling(ceil), .stage_swap(swap), .display_colour_select(sel),
        .peak_bottom_capture_enable(en), .tracking_restart(restart), .stored_peak(stored),
        .output_one_oncount_alarm(al1), .output_two_oncount_alarm(al2),
        .measured_reg(meas_v), .control_output_one(o1), .control_output_two(o2),
        .display_colour_reg(colour), .peak_reg(peak_v), .bottom_reg(bot_v),
        .peak_store_reg(store), .setpoint_rejected_reg(rej),
        .output_one_oncount_monitor(mon1), .output_two_oncount_monitor(mon2),
        .diag_error_reg(diag));
    // Clock of 10 ns period.
    always #5 clock = ~clock;
    // Cuts a hung run short.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            test_done();
        end
    end
    function automatic logic [23:0] seen(input int id);
        case (id)
            0: seen = meas_v;
            1: seen = 24'(o1);
            2: seen = 24'(o2);
            3: seen = 24'(colour);
            4: seen = peak_v;
            5: seen = bot_v;
            6: seen = 24'(rej);
            7: seen = 24'(mon1);
            8: seen = 24'(mon2);
            default: seen = 24'(diag);
        endcase
    endfunction
    // Takes each due note and compares it once the outputs have settled.
    always @(negedge clock)
    begin
        tfs_note_t n;
        logic ok;
        #2;
        while (notes.size() > 0)
        begin
            n = notes.pop_front();
            ok = 1'b0;
            checks++;
            for (int k = -n.tol; k <= n.tol; k++)
                if (seen(n.id) === n.val + 24'(k))
                    ok = 1'b1;
            if (!ok)
            begin
                mismatches++;
                $display("Error %s expected %0d seen %0d", names[n.id], n.val, seen(n.id));
            end
        end
    end
    task automatic note(input int id, input logic [23:0] val, input int tol = 0);
        notes.push_back('{id, val, tol});
    endtask
    task automatic write_sv(input logic [23:0] a, input logic [23:0] b, input logic r);
        @(negedge clock);
        sv1 = a;
        sv2 = b;
        wr = 1'b1;
        @(negedge clock);
        wr = 1'b0;
        @(negedge clock);
        note(6, 24'(r)); // rejection flag
    endtask
    task automatic meas(input int width, input logic e1, input logic e2);
        tfs_pulse_src_inst.send(width);
        note(0, 24'(width), 2); // width measured
        note(1, 24'(e1)); // output one
        note(2, 24'(e2)); // output two
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence of scenarios.
    initial
    begin
        stored = 24'($random(seed)) & 24'h00_003F;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        repeat (100) @(negedge clock);
        note(4, stored); // peak restored while inhibited
        tfs_pulse_src_inst.send(120);
        note(0, 24'h00_0000); // measurement suppressed
        write_sv(24'h00_0001, 24'h00_0001, 1'b0); // clamped ceiling accepts one
        write_sv(24'h00_0002, 24'h00_0001, 1'b1); // clamped ceiling refuses two
        ceil = 24'h00_01F4;
        write_sv(24'h00_01F5, 24'h00_0064, 1'b1); // one above ceiling
        write_sv(24'h00_0064, 24'h00_00C8, 1'b0); // valid pair latched
        en = 1'b1;
        hyst = 24'h00_0014;
        w = 120 + int'($unsigned($random(seed)) % 60);
        meas(w, 1'b1, 1'b0);
        note(3, 24'h00_0002); // second colour when lit
        meas(250, 1'b1, 1'b1);
        note(4, 24'h00_00FA, 2); // peak captured
        meas(90, 1'b1, 1'b0); // inside band stays on
        delay = 32'h0000_0BB8;
        meas(50, 1'b1, 1'b0); // held through delay
        repeat (1500) @(negedge clock);
        note(1, 24'h00_0000); // released after delay
        delay = 32'h0000_0000;
        swap = 1'b1;
        meas(150, 1'b0, 1'b1); // swapped mapping
        for (i = 0; i < 32; i++)
        begin
            sel = i[3:0];
            area = i[4];
            repeat (4) @(negedge clock);
            note(3, 24'(colour_of(sel, !area))); // colour table
        end
        swap = 1'b0;
        sel = 4'h3;
        area = 1'b0;
        sourcing = 1'b0;
        meas(160, 1'b1, 1'b0); // sinking polarity
        repeat (3000) @(negedge clock);
        note(0, 24'h00_00A0, 2); // last width kept
        wmode = 1'b0;
        unit = 1'b1;
        tfs_pulse_src_inst.send(100);
        note(0, 24'h00_00A0, 2); // no cycle result before the gate
        wmode = 1'b1;
        restart = 1'b1;
        @(negedge clock);
        restart = 1'b0;
        meas(180, 1'b1, 1'b0);
        note(4, 24'h00_00B4, 2); // tracking restarted
        note(5, 24'h00_00B4, 2); // bottom tracked
        al1 = 14'h0001;
        al2 = 14'h0001 + 14'($unsigned($random(seed)) % 9999);
        repeat (4) @(negedge clock);
        note(9, 24'h00_0000); // below threshold
        note(7, 24'h00_0000); // monitor one
        note(8, 24'h00_0000); // monitor two
        repeat (2) @(negedge clock);
        test_done();
    end
endmodule // testbench
`default_nettype wire
